//--- rtl/pwd_pkg.sv
// package: register map, fields and reset values of the pulse generator
`default_nettype none

package pwd_pkg;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_COUNT = 8'h00;
  localparam logic [7:0] OFF_LIMIT = 8'h04;
  localparam logic [7:0] OFF_TCTL = 8'h08;
  localparam logic [7:0] OFF_DUTY = 8'h0C;
  localparam logic [7:0] OFF_SHADOW = 8'h10;
  localparam logic [7:0] OFF_MODE = 8'h14;
  localparam logic [7:0] OFF_PORT = 8'h18;
  localparam logic [7:0] OFF_STAT = 8'h1C;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int TCTL_RUN = 2;
  localparam int TCTL_POST_LSB = 3;
  localparam int TCTL_POST_MSB = 6;
  localparam int MODE_LOW_LSB = 4;
  localparam int MODE_LOW_MSB = 5;
  localparam int MODE_SEL_HI = 3;
  localparam int MODE_SEL_MID = 2;
  localparam int PORT_DATA = 0;
  localparam int PORT_DIR = 1;
  localparam int STAT_FLAG = 0;

  // ---------------------------------------------------------------
  // reset values and encodings
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_LIMIT = 8'hFF;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [1:0] RST_PORT = 2'h2;
  localparam logic [1:0] PRE_1 = 2'h0;
  localparam logic [1:0] PRE_4 = 2'h1;
  localparam logic [1:0] MODE_PWM_TOP = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] Q_LAST = 2'h3;
  localparam logic [3:0] PRE_LAST = 4'hF;
  localparam logic [7:0] AGE_MAX = 8'hFF;

endpackage : pwd_pkg

`default_nettype wire

//--- rtl/pwd_prescaler.sv
// time base: instruction phase, prescaler and the two extension bits
`default_nettype none

module pwd_prescaler
  import pwd_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control
  input wire logic run,
  input wire logic clear,
  input wire logic [1:0] prescale_sel,
  // time base
  output logic timer_tick,
  output logic [1:0] ext_bits
);

  logic [1:0] q_reg;
  logic [3:0] pre_reg;

  wire logic inst_tick = (q_reg == Q_LAST);
  wire logic sel_1 = (prescale_sel == PRE_1);
  wire logic sel_4 = (prescale_sel == PRE_4);
  wire logic pre_wrap = sel_1 ? 1'b1 : sel_4 ? (pre_reg[1:0] == Q_LAST) : (pre_reg == PRE_LAST);

  // ---------------------------------------------------------------
  // ratios 1, 4 and 16
  // ---------------------------------------------------------------
  // the extension bits are the sub-phase that advances inside one count
  assign timer_tick = run && inst_tick && pre_wrap; // see RULE7 see RULE14
  assign ext_bits = sel_1 ? q_reg : sel_4 ? pre_reg[1:0] : pre_reg[3:2]; // see RULE5

  // phase runs free; only the prescaler is cleared by software writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q_reg <= 2'h0;
      pre_reg <= 4'h0;
    end else begin
      q_reg <= q_reg + 2'h1;
      if (clear) begin
        pre_reg <= 4'h0;
      end else if (run && inst_tick) begin
        pre_reg <= pre_reg + 4'h1;
      end
    end
  end

endmodule : pwd_prescaler

`default_nettype wire

//--- rtl/pwd_top.sv
// pulse generator with double-buffered 10-bit duty behind an AXI4-Lite slave
//
// Functional notes
// RULE1: duty is high byte plus mode bits 5:4
// RULE2: new duty loads only at period end
// RULE3: shadow byte read-only in pulse mode
// RULE4: shadow byte and 2-bit latch buffer duty
// RULE5: clear pin when shadow equals extended count
// RULE6: duty above period never clears pin
// RULE7: prescale ratios 1, 4 and 16
// RULE8: software sets up period, duty, pin, timer, mode
// RULE9: software clears pin direction bit to drive
// RULE10: after match: clear counter, set pin, load duty
// RULE11: postscaler never affects pulse timing
// RULE12: clearing mode register forces pulse latch low
// RULE13: mode field selects pulse mode, else port
// RULE14: counter advances only while timer enabled
//
// The register offsets and the AXI4-Lite register port were chosen for this implementation.
`default_nettype none

module pwd_top
  import pwd_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi write address
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  // axi write data
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // axi write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi read address
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  // axi read data
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // pulse output pin
  output logic pulse_out,
  output logic pulse_oe
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic awready_reg;
  logic wready_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic [7:0] waddr_reg;
  logic [7:0] wbyte_reg;
  logic wlane_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [1:0] rresp_reg;
  logic [31:0] rdata_reg;

  logic [7:0] count_reg;
  logic [7:0] limit_reg;
  logic [6:0] tctl_reg;
  logic [7:0] duty_reg;
  logic [7:0] shadow_reg;
  logic [1:0] low_latch_reg;
  logic [5:0] mode_reg;
  logic [1:0] port_reg;
  logic flag_reg;
  logic [3:0] post_cnt_reg;
  logic pwm_latch_reg;
  logic pulse_out_reg;
  logic pulse_oe_reg;

  logic timer_tick;
  logic [1:0] ext_bits;

  // ---------------------------------------------------------------
  // bus handshakes and decode
  // ---------------------------------------------------------------
  wire logic aw_hs = awvalid && awready_reg;
  wire logic w_hs = wvalid && wready_reg;
  wire logic b_hs = bvalid_reg && bready;
  wire logic ar_hs = arvalid && arready_reg;
  wire logic r_hs = rvalid_reg && rready;

  // both halves held, response slot free
  wire logic do_write = !awready_reg && !wready_reg && !bvalid_reg;
  // registers are one byte wide, so only lane 0 carries a write
  wire logic wr_en = do_write && wlane_reg;

  wire logic [5:0] wa = waddr_reg[7:2];
  wire logic hw_count = (wa == OFF_COUNT[7:2]);
  wire logic hw_limit = (wa == OFF_LIMIT[7:2]);
  wire logic hw_tctl = (wa == OFF_TCTL[7:2]);
  wire logic hw_duty = (wa == OFF_DUTY[7:2]);
  wire logic hw_shadow = (wa == OFF_SHADOW[7:2]);
  wire logic hw_mode = (wa == OFF_MODE[7:2]);
  wire logic hw_port = (wa == OFF_PORT[7:2]);
  wire logic hw_stat = (wa == OFF_STAT[7:2]);
  wire logic w_hit = hw_count || hw_limit || hw_tctl || hw_duty ||
                     hw_shadow || hw_mode || hw_port || hw_stat;

  wire logic w_count = wr_en && hw_count;
  wire logic w_limit = wr_en && hw_limit;
  wire logic w_tctl = wr_en && hw_tctl;
  wire logic w_duty = wr_en && hw_duty;
  wire logic w_shadow = wr_en && hw_shadow;
  wire logic w_mode = wr_en && hw_mode;
  wire logic w_port = wr_en && hw_port;
  wire logic w_stat = wr_en && hw_stat;

  wire logic [5:0] ra = araddr[7:2];
  wire logic hr_count = (ra == OFF_COUNT[7:2]);
  wire logic hr_limit = (ra == OFF_LIMIT[7:2]);
  wire logic hr_tctl = (ra == OFF_TCTL[7:2]);
  wire logic hr_duty = (ra == OFF_DUTY[7:2]);
  wire logic hr_shadow = (ra == OFF_SHADOW[7:2]);
  wire logic hr_mode = (ra == OFF_MODE[7:2]);
  wire logic hr_port = (ra == OFF_PORT[7:2]);
  wire logic hr_stat = (ra == OFF_STAT[7:2]);
  wire logic r_hit = hr_count || hr_limit || hr_tctl || hr_duty ||
                     hr_shadow || hr_mode || hr_port || hr_stat;

  wire logic [7:0] rbyte =
    hr_count ? count_reg :
    hr_limit ? limit_reg :
    hr_tctl ? {1'b0, tctl_reg} :
    hr_duty ? duty_reg :
    hr_shadow ? shadow_reg :
    hr_mode ? {2'b00, mode_reg} :
    hr_port ? {6'h00, port_reg} :
    hr_stat ? {7'h00, flag_reg} : RST_ZERO;

  // ---------------------------------------------------------------
  // axi4-lite slave
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      waddr_reg <= RST_ZERO;
      wbyte_reg <= RST_ZERO;
      wlane_reg <= 1'b0;
    end else begin
      if (aw_hs) begin
        awready_reg <= 1'b0;
        waddr_reg <= awaddr;
      end
      if (w_hs) begin
        wready_reg <= 1'b0;
        wbyte_reg <= wdata[7:0];
        wlane_reg <= wstrb[0];
      end
      if (do_write) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= w_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (b_hs) begin
        bvalid_reg <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= 32'h0000_0000;
    end else if (ar_hs) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rresp_reg <= r_hit ? RESP_OKAY : RESP_SLVERR;
      rdata_reg <= {24'h00_0000, rbyte};
    end else if (r_hs) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // time base
  // ---------------------------------------------------------------
  wire logic run = tctl_reg[TCTL_RUN];

  // prescaler restarts on counter or control writes, so a new ratio starts clean
  pwd_prescaler u_prescaler (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(run),
    .clear(w_count || w_tctl),
    .prescale_sel(tctl_reg[1:0]),
    .timer_tick(timer_tick),
    .ext_bits(ext_bits)
  );

  // ---------------------------------------------------------------
  // pulse logic
  // ---------------------------------------------------------------
  wire logic pwm_mode = (mode_reg[MODE_SEL_HI:MODE_SEL_MID] == MODE_PWM_TOP); // see RULE13
  wire logic [9:0] duty_value = {duty_reg, mode_reg[MODE_LOW_MSB:MODE_LOW_LSB]}; // see RULE1
  wire logic [9:0] shadow_value = {shadow_reg, low_latch_reg};
  // only the limit ends a period; the postscaler sits downstream of it
  wire logic period_end = timer_tick && (count_reg == limit_reg); // see RULE11
  // a duty above {limit,11} can never be reached by the extended count
  wire logic duty_match = pwm_mode && (shadow_value == {count_reg, ext_bits}); // see RULE5 see RULE6
  wire logic mode_clear = w_mode && (wbyte_reg == RST_ZERO);
  wire logic load_duty = period_end && pwm_mode;
  wire logic post_hit = (post_cnt_reg == tctl_reg[TCTL_POST_MSB:TCTL_POST_LSB]);
  wire logic flag_set = period_end && post_hit;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_reg <= RST_ZERO;
    end else if (w_count) begin
      count_reg <= wbyte_reg;
    end else if (period_end) begin
      count_reg <= RST_ZERO; // see RULE10
    end else if (timer_tick) begin
      count_reg <= count_reg + 8'h01; // see RULE14
    end
  end

  // duty copies reach the comparator only here, never mid-period
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shadow_reg <= RST_ZERO;
      low_latch_reg <= 2'h0;
    end else if (load_duty) begin
      shadow_reg <= duty_reg; // see RULE2 see RULE4 see RULE10
      low_latch_reg <= mode_reg[MODE_LOW_MSB:MODE_LOW_LSB];
    end else if (w_shadow && !pwm_mode) begin
      shadow_reg <= wbyte_reg; // see RULE3
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwm_latch_reg <= 1'b0;
    end else if (mode_clear) begin
      pwm_latch_reg <= 1'b0; // see RULE12
    end else if (load_duty) begin
      pwm_latch_reg <= (duty_value != 10'h000); // see RULE10
    end else if (duty_match) begin
      pwm_latch_reg <= 1'b0; // see RULE5
    end
  end

  // pin registered once more so the output is a clean flop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pulse_out_reg <= 1'b0;
      pulse_oe_reg <= 1'b0;
    end else begin
      pulse_out_reg <= pwm_mode ? pwm_latch_reg : port_reg[PORT_DATA]; // see RULE13
      pulse_oe_reg <= !port_reg[PORT_DIR]; // see RULE9
    end
  end

  // ---------------------------------------------------------------
  // software registers
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      limit_reg <= RST_LIMIT;
      tctl_reg <= 7'h00;
      duty_reg <= RST_ZERO;
      mode_reg <= 6'h00;
      port_reg <= RST_PORT;
    end else begin
      if (w_limit) begin
        limit_reg <= wbyte_reg;
      end
      if (w_tctl) begin
        tctl_reg <= wbyte_reg[6:0];
      end
      if (w_duty) begin
        duty_reg <= wbyte_reg;
      end
      if (w_mode) begin
        mode_reg <= wbyte_reg[5:0];
      end
      if (w_port) begin
        port_reg <= wbyte_reg[1:0];
      end
    end
  end

  // postscaler paces only the flag; set beats a same-cycle clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      post_cnt_reg <= 4'h0;
      flag_reg <= 1'b0;
    end else begin
      if (w_tctl || flag_set) begin
        post_cnt_reg <= 4'h0;
      end else if (period_end) begin
        post_cnt_reg <= post_cnt_reg + 4'h1;
      end
      flag_reg <= flag_set || (flag_reg && !(w_stat && wbyte_reg[STAT_FLAG]));
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign awready = awready_reg;
  assign wready = wready_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign arready = arready_reg;
  assign rvalid = rvalid_reg;
  assign rresp = rresp_reg;
  assign rdata = rdata_reg;
  assign pulse_out = pulse_out_reg;
  assign pulse_oe = pulse_oe_reg;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  logic [7:0] cfg_age_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn || w_tctl || w_count) begin
      cfg_age_reg <= 8'h00;
    end else if (cfg_age_reg != AGE_MAX) begin
      cfg_age_reg <= cfg_age_reg + 8'h01;
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_loaded;
    load_duty ##1 (shadow_value == $past(duty_value));
  endsequence

  property p_duty_load;
    load_duty |-> s_loaded;
  endproperty
  a_duty_load: assert property (p_duty_load) else $error("duty not loaded at period end"); // see RULE1

  property p_shadow_hold;
    (pwm_mode && !load_duty) |=> $stable(shadow_value);
  endproperty
  a_shadow_hold: assert property (p_shadow_hold) else $error("shadow changed mid-period"); // see RULE2

  property p_shadow_ro;
    (w_shadow && pwm_mode && !load_duty) |=> (shadow_reg == $past(shadow_reg));
  endproperty
  a_shadow_ro: assert property (p_shadow_ro) else $error("shadow written in pulse mode"); // see RULE3

  property p_latch_pair;
    load_duty |=> (low_latch_reg == $past(mode_reg[MODE_LOW_MSB:MODE_LOW_LSB]));
  endproperty
  a_latch_pair: assert property (p_latch_pair) else $error("low latch not loaded"); // see RULE4

  property p_match_clear;
    (duty_match && !load_duty && !mode_clear) |=> !pwm_latch_reg ##1 (!$past(pwm_mode) || !pulse_out_reg);
  endproperty
  a_match_clear: assert property (p_match_clear) else $error("pin not cleared on match"); // see RULE5

  property p_no_clear;
    (pwm_mode && (shadow_value > {limit_reg, 2'b11}) && !load_duty && !mode_clear)
      |=> (pwm_latch_reg == $past(pwm_latch_reg));
  endproperty
  a_no_clear: assert property (p_no_clear) else $error("pin cleared past period"); // see RULE6

  property p_prescale4;
    (timer_tick && (tctl_reg[1:0] == PRE_4) && (cfg_age_reg > 8'd40))
      |-> ($past(timer_tick, 16) && !$past(timer_tick, 8) && !$past(timer_tick, 4));
  endproperty
  a_prescale4: assert property (p_prescale4) else $error("prescale 4 spacing wrong"); // see RULE7

  property p_wrap;
    (period_end && !w_count) |=> (count_reg == RST_ZERO);
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter not cleared at period end"); // see RULE10

  property p_set_start;
    (load_duty && !mode_clear && (duty_value != 10'h000)) |=> pwm_latch_reg;
  endproperty
  a_set_start: assert property (p_set_start) else $error("pin not set at period start"); // see RULE10

  property p_limit_only;
    (timer_tick && !w_count && (count_reg < limit_reg)) |=> (count_reg == $past(count_reg) + 8'h01);
  endproperty
  a_limit_only: assert property (p_limit_only) else $error("period ended off limit"); // see RULE11

  property p_mode_clear;
    mode_clear |=> !pwm_latch_reg ##1 (pulse_out_reg == $past(port_reg[PORT_DATA]));
  endproperty
  a_mode_clear: assert property (p_mode_clear) else $error("clear did not force latch low"); // see RULE12

  property p_port_pin;
    (!pwm_mode && $stable(port_reg)) |=> (pulse_out_reg == $past(port_reg[PORT_DATA]));
  endproperty
  a_port_pin: assert property (p_port_pin) else $error("pin not under port control"); // see RULE13

  property p_run_gate;
    (!run && !w_count) |=> $stable(count_reg);
  endproperty
  a_run_gate: assert property (p_run_gate) else $error("counter moved while stopped"); // see RULE14

endmodule : pwd_top

`default_nettype wire

//--- tb/pwd_pin_model.sv
// partner model: load on the pulse pin, measuring period and high time
`default_nettype none

module pwd_pin_model (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // pin as driven by the device
  input wire logic pulse_out,
  input wire logic pulse_oe,
  // resolved level and measurements
  output logic pin_level,
  output logic meas_valid,
  output logic [15:0] meas_period,
  output logic [15:0] meas_high
);
  timeunit 1ns;
  timeprecision 1ps;

  logic last_reg;
  logic prev_reg;
  logic started_reg;
  logic [15:0] cnt_reg;
  logic [15:0] hcnt_reg;
  logic [15:0] hlen_reg;
  logic drv;

  // no pull on the line: undriven it shows the inverse of its last level
  assign pin_level = pulse_oe ? pulse_out : ~last_reg;
  // only a driven pin is measured, so a floating line never fakes a pulse
  assign drv = pulse_oe & pulse_out;

  always_ff @(posedge aclk) begin
    // only a driven level is remembered, so a released line holds its inverse
    if (!aresetn || pulse_oe) begin
      last_reg <= pulse_oe & pulse_out;
    end
    if (!aresetn) begin
      prev_reg <= 1'b0;
      started_reg <= 1'b0;
      cnt_reg <= 16'h0000;
      hcnt_reg <= 16'h0000;
      hlen_reg <= 16'h0000;
      meas_valid <= 1'b0;
      meas_period <= 16'h0000;
      meas_high <= 16'h0000;
    end else begin
      prev_reg <= drv;
      meas_valid <= 1'b0;
      if (drv && !prev_reg) begin
        meas_valid <= started_reg;
        meas_period <= cnt_reg;
        meas_high <= hlen_reg;
        started_reg <= pulse_oe;
        cnt_reg <= 16'h0001;
        hcnt_reg <= 16'h0001;
      end else begin
        cnt_reg <= cnt_reg + 16'h0001;
        if (drv) begin
          hcnt_reg <= hcnt_reg + 16'h0001;
        end
      end
      if (!drv && prev_reg) begin
        hlen_reg <= hcnt_reg;
      end
      if (!pulse_oe) begin
        started_reg <= 1'b0;
      end
    end
  end
endmodule : pwd_pin_model

`default_nettype wire

//--- tb/tb_top.sv
// testbench: register bus master, pin measurements and scoreboard
`default_nettype none

module tb_top
  import pwd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic awready, wready, bvalid, arready, rvalid, pulse_out, pulse_oe, pin_level, meas_valid;
  logic [1:0] bresp, rresp;
  logic [15:0] meas_period, meas_high;
  int failures, checked, cycles;
  logic [33:0] rq[$];
  logic [31:0] mq[$];
  localparam logic [7:0] LIM = 8'h0F;
  localparam logic [7:0] OFFS [8] = '{OFF_COUNT, OFF_LIMIT, OFF_TCTL, OFF_DUTY, OFF_SHADOW, OFF_MODE, OFF_PORT, OFF_STAT};
  localparam logic [7:0] RSTV [8] = '{8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00};

  pwd_top uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .pulse_out(pulse_out), .pulse_oe(pulse_oe));

  pwd_pin_model load (.aclk(aclk), .aresetn(aresetn), .pulse_out(pulse_out), .pulse_oe(pulse_oe),
    .pin_level(pin_level), .meas_valid(meas_valid), .meas_period(meas_period), .meas_high(meas_high));

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // ---------------------------------------------------------------
  // checking and closing
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic stop_test();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test

  function automatic logic [33:0] ok8(input logic [7:0] v);
    return {RESP_OKAY, 24'h0, v};
  endfunction : ok8

  // watcher: each result takes the oldest note
  always @(posedge aclk) begin
    if (rvalid === 1'b1 && rready === 1'b1 && rq.size() > 0) begin
      check("read", {rresp, rdata}, rq.pop_front());
    end
    if (meas_valid === 1'b1 && mq.size() > 0) begin
      check("pulse", {2'h0, meas_period, meas_high}, {2'h0, mq.pop_front()});
    end
  end

  // long ratio-16 periods dominate the run; ceiling leaves ample margin
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      $display("mismatch run_length expected end seen hang");
      stop_test();
    end
  end

  // ---------------------------------------------------------------
  // bus master
  // ---------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] exp_resp);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {24'h0, d};
    wstrb <= 4'hF;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    check("bresp", {32'h0, bresp}, {32'h0, exp_resp});
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [33:0] exp);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    rq.push_back(exp);
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    @(posedge aclk);
  endtask : rd

  // ---------------------------------------------------------------
  // pulse set-up and measurement
  // ---------------------------------------------------------------
  task automatic setup(input logic [1:0] ps, input logic [9:0] duty);
    wr(OFF_LIMIT, LIM, RESP_OKAY);
    wr(OFF_DUTY, duty[9:2], RESP_OKAY);
    wr(OFF_MODE, {2'h0, duty[1:0], 4'h0}, RESP_OKAY);
    wr(OFF_PORT, 8'h00, RESP_OKAY);
    wr(OFF_TCTL, {5'h00, 1'b1, ps}, RESP_OKAY);
    wr(OFF_MODE, {2'h0, duty[1:0], 4'hC}, RESP_OKAY);
  endtask : setup

  // first two periods may be cut short by the set-up writes
  task automatic measure(input logic [1:0] ps, input logic [9:0] duty);
    int r;
    r = (ps == PRE_1) ? 1 : (ps == PRE_4) ? 4 : 16;
    repeat (2) @(posedge meas_valid);
    // wait until the second result has been seen, so the third is compared
    @(negedge meas_valid);
    // the clear lands one clock after the match is seen
    mq.push_back({16'((LIM + 1) * 4 * r), 16'(int'(duty) * r + 1)});
    @(posedge meas_valid);
    @(posedge aclk);
  endtask : measure

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    int unsigned rnd;
    int lows;
    logic [9:0] duty;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'h0;
    rnd = $urandom(32'h8927);
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    foreach (OFFS[i]) rd(OFFS[i], ok8(RSTV[i]));
    rd(8'h20, {RESP_SLVERR, 32'h0});
    wr(8'h20, 8'h55, RESP_SLVERR);
    $display("test reset_map done");
    for (int p = 0; p < 3; p++) begin
      // 63 fills the whole period at ratio 1, so the pin would never fall there
      duty = 10'($urandom_range(62, 1));
      setup(2'(p), duty);
      measure(2'(p), duty);
    end
    $display("test prescale done");
    wr(OFF_TCTL, 8'h7E, RESP_OKAY);
    measure(2'h2, duty);
    $display("test postscale done");
    wr(OFF_DUTY, 8'h09, RESP_OKAY);
    rd(OFF_SHADOW, ok8(duty[9:2]));
    wr(OFF_SHADOW, 8'hA5, RESP_OKAY);
    rd(OFF_SHADOW, ok8(duty[9:2]));
    @(posedge meas_valid);
    @(posedge aclk);
    rd(OFF_SHADOW, ok8(8'h09));
    measure(2'h2, {8'h09, duty[1:0]});
    $display("test double_buffer done");
    wr(OFF_TCTL, 8'h04, RESP_OKAY);
    wr(OFF_DUTY, 8'hFF, RESP_OKAY);
    repeat (200) @(posedge aclk);
    lows = 0;
    repeat (128) begin
      @(posedge aclk);
      if (pulse_out !== 1'b1) lows++;
    end
    check("low_cycles", 34'(lows), 34'h0);
    $display("test duty_over_period done");
    wr(OFF_MODE, 8'h00, RESP_OKAY);
    repeat (3) @(posedge aclk);
    check("latch_low", {33'h0, pulse_out}, 34'h0);
    wr(OFF_PORT, 8'h01, RESP_OKAY);
    repeat (3) @(posedge aclk);
    check("port_drive", {31'h0, pulse_oe, pulse_out, pin_level}, 34'h7);
    wr(OFF_PORT, 8'h02, RESP_OKAY);
    repeat (3) @(posedge aclk);
    check("port_release", {32'h0, pulse_oe, pin_level}, 34'h0);
    $display("test port_mode done");
    wr(OFF_TCTL, 8'h00, RESP_OKAY);
    wr(OFF_COUNT, 8'h05, RESP_OKAY);
    repeat (100) @(posedge aclk);
    rd(OFF_COUNT, ok8(8'h05));
    $display("test timer_stop done");
    stop_test();
  end
endmodule : tb_top

`default_nettype wire
